// ===== rtl/dma_hs_map.vh
// Register offsets, field positions and reset values of the DMA transaction handshake block.
`ifndef DMA_HS_MAP_VH
`define DMA_HS_MAP_VH
`define DH_CH_STRIDE 3'd5
`define DH_OFF_SAR 5'h00
`define DH_OFF_DAR 5'h04
`define DH_OFF_LLP 5'h08
`define DH_OFF_CTL 5'h0c
`define DH_OFF_CFG 5'h10
`define DH_OFF_SRC_BURST 8'h40
`define DH_OFF_DST_BURST 8'h44
`define DH_OFF_SRC_SINGLE 8'h48
`define DH_OFF_DST_SINGLE 8'h4c
`define DH_OFF_SRC_LAST 8'h50
`define DH_OFF_DST_LAST 8'h54
`define DH_OFF_STATUS 8'h58
`define DH_CFG_ENABLE 0
`define DH_CFG_SRC_HS 1
`define DH_CFG_DST_HS 2
`define DH_CFG_SRC_MEM 3
`define DH_CFG_DST_MEM 4
`define DH_CFG_SRC_FC 5
`define DH_CFG_DST_FC 6
`define DH_CFG_RELOAD_SR 7
`define DH_CFG_RELOAD_DS 8
`define DH_CFG_SRC_IF_LSB 9
`define DH_CFG_DST_IF_LSB 12
`define DH_CFG_IRQ_EN 15
`define DH_CFG_MASK 32'h0000ffff
`define DH_CTL_LLP_S_EN 6
`define DH_CTL_LLP_D_EN 7
`define DH_CTL_MASK 32'h000fffff
`define DH_RST_WORD 32'h00000000
`define DH_RST_CFG 32'h00000000
`endif

// ===== rtl/ext_request_sync.v
// Resynchroniser and rising-edge detector for the active-low external request inputs.
`timescale 1ns/1ps
module ext_request_sync (
    input wire pclk,
    input wire presetn,
    input wire [3:0] ext_request_n,
    output wire [3:0] request_rise
);
    reg [3:0] stage1;
    reg [3:0] stage2;
    reg [3:0] request_prev;

    // The first stage only feeds the second; the edge is taken after the second.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= 4'hf;
            stage2 <= 4'hf;
            request_prev <= 4'h0;
        end else begin
            stage1 <= ext_request_n;
            stage2 <= stage1;
            request_prev <= ~stage2;
        end
    end

    assign request_rise = ~stage2 & ~request_prev;
endmodule // ext_request_sync

// ===== rtl/dma_transaction_handshake.v
// Transaction request logic of a two-channel DMA controller with APB register access.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "dma_hs_map.vh"
// Functional notes
// - Memory targets transfer as soon as the channel is enabled, never flow controller.
// - Each channel selects hardware or software handshaking for source and destination.
// - Handshake-select bits in channel configuration choose software handshaking.
// - Last-transaction request bits are ignored unless the peripheral controls flow.
// - Burst bit requests a burst; it starts once the single bit is also set.
// - A finished software burst clears that channel's single and burst bits.
// - Single bit alone starts a single transaction; completion clears both bits.
// - A burst bit written during a running single transaction has no effect.
// - Both request bits reading zero means the transaction is complete.
// - Source or destination done interrupt fires after each transaction, when enabled.
// - External requests 0 to 3 drive hardware interfaces 1 to 4 of five.
// - Active-low external requests are resynchronised; the rising edge starts transfer.
// - The internal request drops when the interface acknowledge is given.
// - Addresses update by descriptor, reload or continuation; control by descriptor or reload.
// - In linked-list mode the pointer reloads only from the fetched descriptor.
// - Descriptor holds addresses, pointer and control; with configuration it defines a block.
// - A peripheral signals readiness by handshake so it needs no wait states.
// - The flow controller, controller or peripheral, sets block length and ends it.
module dma_transaction_handshake (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire [3:0] ext_request_n,
    input wire hw_request0,
    output reg [4:0] hw_ack,
    output reg [3:0] mem_go,
    output reg [3:0] txn_start,
    output reg [3:0] txn_burst,
    output reg [3:0] txn_last,
    input wire [3:0] txn_complete,
    output reg [1:0] source_transaction_done_irq,
    output reg [1:0] destination_transaction_done_irq,
    input wire block_end,
    input wire block_ch,
    input wire [31:0] end_sar,
    input wire [31:0] end_dar,
    input wire desc_valid,
    input wire desc_ch,
    input wire [31:0] desc_sar,
    input wire [31:0] desc_dar,
    input wire [31:0] desc_llp,
    input wire [31:0] desc_ctl,
    output wire [63:0] source_address_flat,
    output wire [63:0] destination_address_flat,
    output wire [63:0] next_descriptor_pointer_flat,
    output wire [63:0] channel_control_flat
);
    reg [31:0] source_address [0:1];
    reg [31:0] destination_address [0:1];
    reg [31:0] next_descriptor_pointer [0:1];
    reg [31:0] channel_control [0:1];
    reg [31:0] channel_configuration [0:1];
    reg [31:0] init_sar [0:1];
    reg [31:0] init_dar [0:1];
    reg [31:0] init_llp [0:1];
    reg [31:0] init_ctl [0:1];
    reg [3:0] single_req;
    reg [3:0] burst_req;
    reg [3:0] last_req;
    reg [3:0] active;
    reg [4:0] pend;
    reg hw0_prev;
    reg [3:0] start;
    reg [4:0] next_ack;
    wire [3:0] ext_rise;
    wire wr_en;
    wire setup_rd;
    integer i;
    integer l;
    integer m;
    integer j;

    // Lane l serves channel l/2; even lanes are sources, odd lanes destinations.
    function lane_bit;
        input [31:0] cfg;
        input side;
        input integer src_pos;
        input integer dst_pos;
        begin
            lane_bit = side ? cfg[dst_pos] : cfg[src_pos];
        end
    endfunction

    function [2:0] lane_if;
        input [31:0] cfg;
        input side;
        begin
            lane_if = side ? cfg[`DH_CFG_DST_IF_LSB +: 3] : cfg[`DH_CFG_SRC_IF_LSB +: 3];
        end
    endfunction

    // Returns 0 or 1 for a channel register address and 2 when it is not one.
    function [1:0] chan_hit;
        input [7:0] addr;
        begin
            if (addr[7:6] == 2'b00 && addr[4:0] <= `DH_OFF_CFG && addr[1:0] == 2'b00)
                chan_hit = {1'b0, addr[5]};
            else
                chan_hit = 2'd2;
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = (chan_hit(addr) != 2'd2) || (addr >= `DH_OFF_SRC_BURST &&
                addr <= `DH_OFF_STATUS && addr[1:0] == 2'b00);
        end
    endfunction

    ext_request_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ext_request_n(ext_request_n),
        .request_rise(ext_rise)
    );

    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign setup_rd = psel & ~penable;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_flat
            assign source_address_flat[g*32 +: 32] = source_address[g];
            assign destination_address_flat[g*32 +: 32] = destination_address[g];
            assign next_descriptor_pointer_flat[g*32 +: 32] = next_descriptor_pointer[g];
            assign channel_control_flat[g*32 +: 32] = channel_control[g];
        end
    endgenerate

    // Transaction start and interface acknowledge decisions for every lane.
    always @* begin
        start = 4'h0;
        next_ack = 5'h00;
        // A request still pending while its acknowledge stands belongs to the finished transaction.
        for (m = 0; m < 4; m = m + 1) begin
            if (channel_configuration[m/2][`DH_CFG_ENABLE] && !active[m] &&
                !lane_bit(channel_configuration[m/2], m[0], `DH_CFG_SRC_MEM, `DH_CFG_DST_MEM)) begin
                if (lane_bit(channel_configuration[m/2], m[0], `DH_CFG_SRC_HS, `DH_CFG_DST_HS))
                    start[m] = single_req[m];
                else if (lane_if(channel_configuration[m/2], m[0]) <= 3'd4)
                    start[m] = pend[lane_if(channel_configuration[m/2], m[0])] &
                        ~hw_ack[lane_if(channel_configuration[m/2], m[0])];
            end
            if (active[m] && txn_complete[m] &&
                !lane_bit(channel_configuration[m/2], m[0], `DH_CFG_SRC_HS, `DH_CFG_DST_HS) &&
                lane_if(channel_configuration[m/2], m[0]) <= 3'd4)
                next_ack[lane_if(channel_configuration[m/2], m[0])] = 1'b1;
        end
    end

    // Lane state, requests and acknowledges.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            single_req <= 4'h0;
            burst_req <= 4'h0;
            last_req <= 4'h0;
            active <= 4'h0;
            pend <= 5'h00;
            hw0_prev <= 1'b0;
            hw_ack <= 5'h00;
            mem_go <= 4'h0;
            txn_start <= 4'h0;
            txn_burst <= 4'h0;
            txn_last <= 4'h0;
            source_transaction_done_irq <= 2'b00;
            destination_transaction_done_irq <= 2'b00;
        end else begin
            hw0_prev <= hw_request0;
            hw_ack <= next_ack;
            txn_start <= start;
            // A new rising edge wins over the acknowledge that drops the old one.
            pend <= (pend & ~hw_ack) | {ext_rise, hw_request0 & ~hw0_prev};
            for (l = 0; l < 4; l = l + 1) begin
                mem_go[l] <= channel_configuration[l/2][`DH_CFG_ENABLE] &
                    lane_bit(channel_configuration[l/2], l[0], `DH_CFG_SRC_MEM, `DH_CFG_DST_MEM);
                // Last requests count only when this peripheral is the flow controller.
                txn_last[l] <= last_req[l] & active[l] &
                    lane_bit(channel_configuration[l/2], l[0], `DH_CFG_SRC_HS, `DH_CFG_DST_HS) &
                    lane_bit(channel_configuration[l/2], l[0], `DH_CFG_SRC_FC, `DH_CFG_DST_FC) &
                    ~lane_bit(channel_configuration[l/2], l[0], `DH_CFG_SRC_MEM, `DH_CFG_DST_MEM);
                if (start[l]) begin
                    active[l] <= 1'b1;
                    txn_burst[l] <= lane_bit(channel_configuration[l/2], l[0], `DH_CFG_SRC_HS,
                        `DH_CFG_DST_HS) ? burst_req[l] : 1'b1;
                end else if (active[l] && txn_complete[l]) begin
                    active[l] <= 1'b0;
                end
                if (active[l] && txn_complete[l] && lane_bit(channel_configuration[l/2], l[0],
                        `DH_CFG_SRC_HS, `DH_CFG_DST_HS)) begin
                    single_req[l] <= 1'b0;
                    burst_req[l] <= 1'b0;
                end
                if (l[0]) begin
                    destination_transaction_done_irq[l/2] <= active[l] & txn_complete[l] &
                        channel_configuration[l/2][`DH_CFG_IRQ_EN];
                end else begin
                    source_transaction_done_irq[l/2] <= active[l] & txn_complete[l] &
                        channel_configuration[l/2][`DH_CFG_IRQ_EN];
                end
            end
            // Software sets are placed last so that a write wins over a hardware clear.
            if (wr_en) begin
                for (j = 0; j < 2; j = j + 1) begin
                    if (paddr == `DH_OFF_SRC_SINGLE && pwdata[j])
                        single_req[2*j] <= 1'b1;
                    if (paddr == `DH_OFF_DST_SINGLE && pwdata[j])
                        single_req[2*j+1] <= 1'b1;
                    // A running single transaction ignores a burst request.
                    if (paddr == `DH_OFF_SRC_BURST && pwdata[j] && !(active[2*j] && !txn_burst[2*j]))
                        burst_req[2*j] <= 1'b1;
                    if (paddr == `DH_OFF_DST_BURST && pwdata[j] &&
                        !(active[2*j+1] && !txn_burst[2*j+1]))
                        burst_req[2*j+1] <= 1'b1;
                    if (paddr == `DH_OFF_SRC_LAST)
                        last_req[2*j] <= pwdata[j];
                    if (paddr == `DH_OFF_DST_LAST)
                        last_req[2*j+1] <= pwdata[j];
                end
            end
        end
    end

    // Channel registers: software writes, then block-boundary updates which take priority.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 2; i = i + 1) begin
                source_address[i] <= `DH_RST_WORD;
                destination_address[i] <= `DH_RST_WORD;
                next_descriptor_pointer[i] <= `DH_RST_WORD;
                channel_control[i] <= `DH_RST_WORD;
                channel_configuration[i] <= `DH_RST_CFG;
                init_sar[i] <= `DH_RST_WORD;
                init_dar[i] <= `DH_RST_WORD;
                init_llp[i] <= `DH_RST_WORD;
                init_ctl[i] <= `DH_RST_WORD;
            end
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                if (wr_en && chan_hit(paddr) == i[1:0]) begin
                    case (paddr[4:0])
                        `DH_OFF_SAR: source_address[i] <= pwdata;
                        `DH_OFF_DAR: destination_address[i] <= pwdata;
                        `DH_OFF_LLP: next_descriptor_pointer[i] <= pwdata;
                        `DH_OFF_CTL: channel_control[i] <= pwdata & `DH_CTL_MASK;
                        `DH_OFF_CFG: begin
                            channel_configuration[i] <= pwdata & `DH_CFG_MASK;
                            // Enabling a channel captures the values that auto-reload restores.
                            if (pwdata[`DH_CFG_ENABLE] && !channel_configuration[i][`DH_CFG_ENABLE]) begin
                                init_sar[i] <= source_address[i];
                                init_dar[i] <= destination_address[i];
                                init_llp[i] <= next_descriptor_pointer[i];
                                init_ctl[i] <= channel_control[i];
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                if (block_end && block_ch == i[0]) begin
                    if (!channel_control[i][`DH_CTL_LLP_S_EN])
                        source_address[i] <= channel_configuration[i][`DH_CFG_RELOAD_SR] ?
                            init_sar[i] : end_sar;
                    if (!channel_control[i][`DH_CTL_LLP_D_EN])
                        destination_address[i] <= channel_configuration[i][`DH_CFG_RELOAD_DS] ?
                            init_dar[i] : end_dar;
                    // Control and pointer are never continued, only reloaded or fetched.
                    if (!channel_control[i][`DH_CTL_LLP_S_EN] && !channel_control[i][`DH_CTL_LLP_D_EN] &&
                        (channel_configuration[i][`DH_CFG_RELOAD_SR] |
                        channel_configuration[i][`DH_CFG_RELOAD_DS])) begin
                        channel_control[i] <= init_ctl[i];
                        next_descriptor_pointer[i] <= init_llp[i];
                    end
                end
                if (desc_valid && desc_ch == i[0] &&
                    (channel_control[i][`DH_CTL_LLP_S_EN] | channel_control[i][`DH_CTL_LLP_D_EN])) begin
                    if (channel_control[i][`DH_CTL_LLP_S_EN])
                        source_address[i] <= desc_sar;
                    if (channel_control[i][`DH_CTL_LLP_D_EN])
                        destination_address[i] <= desc_dar;
                    next_descriptor_pointer[i] <= desc_llp;
                    channel_control[i] <= desc_ctl & `DH_CTL_MASK;
                end
            end
        end
    end

    // Read data and error are captured in the setup cycle and shown in the access phase.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_rd) begin
            pslverr <= ~mapped(paddr);
            prdata <= 32'h00000000;
            if (!pwrite) begin
                if (chan_hit(paddr) != 2'd2) begin
                    case (paddr[4:0])
                        `DH_OFF_SAR: prdata <= source_address[paddr[5]];
                        `DH_OFF_DAR: prdata <= destination_address[paddr[5]];
                        `DH_OFF_LLP: prdata <= next_descriptor_pointer[paddr[5]];
                        `DH_OFF_CTL: prdata <= channel_control[paddr[5]];
                        default: prdata <= channel_configuration[paddr[5]];
                    endcase
                end else begin
                    case (paddr)
                        `DH_OFF_SRC_BURST: prdata <= {30'h0, burst_req[2], burst_req[0]};
                        `DH_OFF_DST_BURST: prdata <= {30'h0, burst_req[3], burst_req[1]};
                        `DH_OFF_SRC_SINGLE: prdata <= {30'h0, single_req[2], single_req[0]};
                        `DH_OFF_DST_SINGLE: prdata <= {30'h0, single_req[3], single_req[1]};
                        `DH_OFF_SRC_LAST: prdata <= {30'h0, last_req[2], last_req[0]};
                        `DH_OFF_DST_LAST: prdata <= {30'h0, last_req[3], last_req[1]};
                        `DH_OFF_STATUS: prdata <= {23'h0, pend, active};
                        default: prdata <= 32'h00000000;
                    endcase
                end
            end
        end
    end
endmodule // dma_transaction_handshake

// ===== bench/dma_hs_props.sv
// Port-level assertions of the DMA transaction handshake block.
`timescale 1ns/1ps
module dma_hs_props (
    input wire pclk,
    input wire presetn,
    input wire [4:0] hw_ack,
    input wire [3:0] mem_go,
    input wire [3:0] txn_start,
    input wire [3:0] txn_burst,
    input wire [3:0] txn_complete,
    input wire [1:0] source_transaction_done_irq,
    input wire [1:0] destination_transaction_done_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_mem_quiet; (mem_go & txn_start) == 4'h0; endproperty
    a_mem_quiet: assert property (p_mem_quiet) else $error("memory lane started a transaction");
    property p_start_pulse; (txn_start & $past(txn_start)) == 4'h0; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start lasted two cycles");
    property p_burst_hold; ((txn_burst ^ $past(txn_burst)) & ~txn_start) == 4'h0; endproperty
    a_burst_hold: assert property (p_burst_hold) else $error("burst kind changed without a start");
    property p_src_done;
        (source_transaction_done_irq & ~{$past(txn_complete[2]), $past(txn_complete[0])}) == 2'b00;
    endproperty
    a_src_done: assert property (p_src_done) else $error("source done without completion");
    property p_dst_done;
        (destination_transaction_done_irq & ~{$past(txn_complete[3]), $past(txn_complete[1])}) == 2'b00;
    endproperty
    a_dst_done: assert property (p_dst_done) else $error("destination done without completion");
    property p_done_pulse; source_transaction_done_irq[0] |=> (!source_transaction_done_irq[0]) [*2]; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
    property p_ack_cause; |hw_ack |-> $past(|txn_complete); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without completion");
    property p_ack_pulse; (hw_ack & $past(hw_ack)) == 5'h00; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge lasted two cycles");
endmodule // dma_hs_props

// ===== bench/dma_far_side.sv
// Peripheral request and master-side completion model for the handshake block.
`timescale 1ns/1ps
module dma_far_side (
    input wire pclk,
    input wire presetn,
    input wire [4:0] raise,
    input wire slow,
    input wire [4:0] hw_ack,
    input wire [3:0] txn_start,
    output reg [3:0] txn_complete,
    output wire [3:0] ext_request_n,
    output wire hw_request0
);
    reg [4:0] level;
    reg [3:0] cnt [0:3];
    integer i;
    assign ext_request_n = ~level[4:1];
    assign hw_request0 = level[0];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 5'h00;
            txn_complete <= 4'h0;
            for (i = 0; i < 4; i = i + 1)
                cnt[i] <= 4'h0;
        end else begin
            // A request is held until acknowledged, then released before the next transaction.
            level <= (level | raise) & ~hw_ack;
            for (i = 0; i < 4; i = i + 1) begin
                txn_complete[i] <= (cnt[i] == 4'h1);
                if (txn_start[i])
                    cnt[i] <= slow ? 4'hc : 4'h2;
                else if (cnt[i] != 4'h0)
                    cnt[i] <= cnt[i] - 4'h1;
            end
        end
    end
endmodule // dma_far_side

// ===== bench/dma_transaction_handshake_tb.sv
// Self-checking testbench of the DMA transaction handshake block.
`timescale 1ns/1ps
bind dma_transaction_handshake dma_hs_props dma_hs_props_inst (.pclk(pclk), .presetn(presetn),
    .hw_ack(hw_ack), .mem_go(mem_go), .txn_start(txn_start), .txn_burst(txn_burst),
    .txn_complete(txn_complete), .source_transaction_done_irq(source_transaction_done_irq),
    .destination_transaction_done_irq(destination_transaction_done_irq));
module dma_transaction_handshake_tb;
    logic pclk, presetn, psel, penable, pwrite, block_end, desc_valid, slow, b, err, bch;
    logic [7:0] paddr;
    logic [31:0] pwdata, end_sar, end_dar, desc_sar, desc_dar, desc_ctl, desc_llp, rd, bit_n;
    logic [4:0] raise;
    wire pready, pslverr, hw_request0;
    wire [31:0] prdata;
    wire [3:0] ext_request_n, mem_go, txn_start, txn_burst, txn_last, txn_complete;
    wire [4:0] hw_ack;
    wire [1:0] src_irq, dst_irq;
    wire [63:0] sar_flat, dar_flat, llp_flat, ctl_flat;
    wire [12:0] ev = {hw_ack, dst_irq, src_irq, txn_start};
    integer mismatches, num_checks, lane, k, n;
    dma_transaction_handshake dma_transaction_handshake_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ext_request_n(ext_request_n), .hw_request0(hw_request0), .hw_ack(hw_ack),
        .mem_go(mem_go), .txn_start(txn_start), .txn_burst(txn_burst), .txn_last(txn_last),
        .txn_complete(txn_complete), .source_transaction_done_irq(src_irq),
        .destination_transaction_done_irq(dst_irq), .block_end(block_end), .block_ch(bch),
        .end_sar(end_sar), .end_dar(end_dar), .desc_valid(desc_valid), .desc_ch(bch), .desc_sar(desc_sar),
        .desc_dar(desc_dar), .desc_llp(desc_llp), .desc_ctl(desc_ctl), .source_address_flat(sar_flat),
        .destination_address_flat(dar_flat), .next_descriptor_pointer_flat(llp_flat),
        .channel_control_flat(ctl_flat));
    dma_far_side dma_far_side_inst (.pclk(pclk), .presetn(presetn), .raise(raise), .slow(slow),
        .hw_ack(hw_ack), .txn_start(txn_start), .txn_complete(txn_complete),
        .ext_request_n(ext_request_n), .hw_request0(hw_request0));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task timeout_out;
        mismatches = mismatches + 1;
        $display("MISMATCH %0t wait ran out", $time);
        print_verdict;
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
            timeout_out;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_ev(input integer idx);
        n = 0;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (ev[idx] !== 1'b1 && n < 40);
        if (ev[idx] !== 1'b1)
            timeout_out;
    endtask
    task strobe(input logic d);
        block_end <= !d;
        desc_valid <= d;
        @(posedge pclk);
        block_end <= 1'b0;
        desc_valid <= 1'b0;
        @(posedge pclk);
    endtask
    function integer done_index(input integer l);
        return 4 + (l % 2) * 2 + l / 2;
    endfunction
    initial begin
        k = $urandom(32'h62f4e308);
        {presetn, psel, penable, pwrite, block_end, desc_valid, slow, bch, paddr, pwdata, raise} = '0;
        {end_sar, end_dar, desc_sar, desc_dar, desc_ctl, desc_llp, mismatches, num_checks} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        apb(1, 8'h14, 32'h5);
        chk(32'(err), 32'h1);
        apb(1, 8'h10, 32'h19);
        apb(0, 8'h58, 32'h0);
        chk(32'(mem_go), 32'h3);
        chk(rd, 32'h0);
        apb(1, 8'h50, 32'h3);
        apb(1, 8'h54, 32'h3);
        apb(1, 8'h0c, 32'h9);
        apb(1, 8'h10, 32'h8007);
        apb(1, 8'h30, 32'h8007);
        for (k = 0; k < 8; k = k + 1) begin
            lane = k % 4;
            b = (k < 4) ? lane[0] : !lane[0];
            slow <= b ? $urandom % 2 : 1'b1;
            bit_n = 32'h1 << (lane / 2);
            if (b)
                apb(1, 8'h40 + 4 * (lane % 2), bit_n);
            apb(1, 8'h48 + 4 * (lane % 2), bit_n);
            wait_ev(lane);
            chk(32'(txn_burst[lane]), 32'(b));
            chk(32'(txn_last), 32'h0);
            if (!b) begin
                apb(1, 8'h40 + 4 * (lane % 2), bit_n);
                apb(0, 8'h40 + 4 * (lane % 2), 32'h0);
                chk(rd & bit_n, 32'h0);
            end
            wait_ev(done_index(lane));
            apb(0, 8'h40 + 4 * (lane % 2), 32'h0);
            chk(rd, 32'h0);
            apb(0, 8'h48 + 4 * (lane % 2), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1, 8'h30, 32'h8067);
        slow <= 1'b1;
        apb(1, 8'h48, 32'h2);
        apb(1, 8'h4c, 32'h2);
        apb(0, 8'h58, 32'h0);
        chk(32'(txn_last), 32'hc);
        chk(rd, 32'hc);
        for (k = 0; k < 5; k = k + 1) begin
            apb(1, 8'h10, 32'h8005 | (k << 9));
            raise <= 5'h1 << k;
            @(posedge pclk);
            raise <= 5'h00;
            wait_ev(0);
            wait_ev(8 + k);
            chk(32'(hw_ack), 32'h1 << k);
            apb(0, 8'h58, 32'h0);
            chk(rd & 32'h1f3, 32'h0);
        end
        end_sar <= $urandom;
        end_dar <= $urandom;
        strobe(1'b0);
        chk(sar_flat[31:0], end_sar);
        chk(ctl_flat[31:0], 32'h9);
        apb(1, 8'h0c, 32'hc9);
        desc_sar <= $urandom;
        desc_llp <= $urandom & 32'hfffffffc;
        desc_dar <= $urandom;
        desc_ctl <= ($urandom & 32'h000fffff) | 32'h000000c0;
        strobe(1'b1);
        chk(llp_flat[31:0], desc_llp);
        chk(sar_flat[31:0], desc_sar);
        chk(dar_flat[31:0], desc_dar);
        chk(ctl_flat[31:0], desc_ctl);
        strobe(1'b0);
        chk(llp_flat[31:0], desc_llp);
        chk(sar_flat[31:0], desc_sar);
        bch <= 1'b1;
        strobe(1'b1);
        chk(llp_flat[63:32], 32'h0);
        chk(llp_flat[31:0], desc_llp);
        print_verdict;
    end
endmodule // dma_transaction_handshake_tb
